// >>> src/psf_top.sv
// Purge scheduler, measurement masking, pressure setpoint and output filter.
// Assumes free-running core_clk, synchronous inputs and a simple register port.
`timescale 1ns/1ps
// Overview of operation
// - Purge heats sensors four minutes, then measures.
// - Both outputs read unavailable during purge.
// - Purge at power-up and after humidity adjustment.
// - Periodic purge, default 24 h, 1 h..1 week.
// - Defer periodic purge 30 min if wet/unsteady.
// - Setting allows purge during peroxide presence.
// - Purge on bus command or pin drive.
// - Host writes pressure setpoint used for compensation.
// - Compensation off at reset; use 1013.25 hPa.
// - Filter coefficient writable at 0x308.
// - Coefficient defaults to 1.0, no filtering.
// - Output blends latest sample with previous output.
// - Peroxide equals plain minus catalytic reading.
// - Analog mode forces error current during purge.
// - Output-control pin picks mode once after reset; in analog mode its drops then request purges.
module psf_top
  import psf_pkg::*;
#(
  parameter longint unsigned PURGE_CYCLES = PURGE_CYC,
  parameter longint unsigned DEFER_CYCLES = DEFER_CYC,
  parameter longint unsigned HOUR_CYCLES  = HOUR_CYC,
  parameter int              W            = 32
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // Register port
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [31:0]   reg_wdata,
  output logic      [31:0]   reg_rdata,
  // Environment and pins
  input  wire logic          out_ctl_pin_n,
  input  wire logic          rh_adjust_done,
  input  wire logic          peroxide_present,
  input  wire logic          humidity_unsteady,
  // Sensor readings
  input  wire logic          smp_valid,
  input  wire logic [W-1:0]  plain_rdg,
  input  wire logic [W-1:0]  catal_rdg,
  // Outputs
  output logic               analog_mode,
  output logic               purge_active,
  output logic               meas_valid,
  output logic      [W-1:0]  peroxide_out,
  output logic      [W-1:0]  water_out,
  output logic               analog_err,
  output logic      [31:0]   comp_pressure
);
  psf_state_t        state;
  psf_state_t        next_state;
  logic [63:0]       tmr;
  logic [63:0]       per_cnt;
  logic [63:0]       per_lim;
  logic              defer_wait;
  logic              mode_taken;
  logic              pin_q;
  logic [31:0]       filt_coef;
  logic [31:0]       press_set;
  logic [31:0]       purge_ival;
  logic              comp_en;
  logic              purge_wet;
  logic              cmd_req;
  logic [W-1:0]      perox_raw;
  logic [W-1:0]      perox_f;
  logic [W-1:0]      water_f;

  // Register decode.
  wire wr_coef  = reg_wr && reg_addr == REG_FILT_COEF;
  wire wr_press = reg_wr && reg_addr == REG_PRESS_SET;
  wire wr_ctrl  = reg_wr && reg_addr == REG_PURGE_CTRL;
  wire wr_ival  = reg_wr && reg_addr == REG_PURGE_IVAL;
  wire ival_ok  = reg_wdata >= PERIOD_MIN_H && reg_wdata <= PERIOD_MAX_H;

  // Request sources; a fresh pin drop is the analog-mode trigger.
  wire pin_req   = analog_mode && mode_taken && pin_q && !out_ctl_pin_n;
  wire any_req   = cmd_req || pin_req || rh_adjust_done;
  wire per_due   = per_cnt >= per_lim;
  wire blocked   = (peroxide_present && !purge_wet) || humidity_unsteady;
  wire start_per = per_due && !blocked;
  wire purge_end = (state == PSF_PURGE) && (tmr == PURGE_CYCLES - 1);

  assign per_lim = 64'(purge_ival) * HOUR_CYCLES;

  // Purge state choice; requests during purge fall through unused.
  always_comb begin
    next_state = state;
    case (state)
      PSF_IDLE:  if (!mode_taken || any_req || start_per) next_state = PSF_PURGE;
      PSF_PURGE: if (purge_end) next_state = PSF_IDLE;
      default:   next_state = PSF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= PSF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Purge timer, period counter and deferral delay.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tmr        <= '0;
      per_cnt    <= '0;
      defer_wait <= 1'b0;
    end else begin
      tmr <= (state == PSF_PURGE && !purge_end) ? tmr + 64'd1 : '0;
      if (state == PSF_PURGE || purge_end) begin
        per_cnt    <= '0;
        defer_wait <= 1'b0;
      end else if (defer_wait) begin
        // Re-check only after each full deferral delay.
        if (per_cnt >= DEFER_CYCLES - 1) begin
          per_cnt <= per_lim;
          defer_wait <= 1'b0;
        end else begin
          per_cnt <= per_cnt + 64'd1;
        end
      end else if (per_due && blocked) begin
        per_cnt    <= '0;
        defer_wait <= 1'b1;
      end else if (!per_due) begin
        per_cnt <= per_cnt + 64'd1;
      end
    end
  end

  // Mode strap caught once after reset release; the pin is low for analog.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_taken  <= 1'b0;
      analog_mode <= 1'b0;
      pin_q       <= 1'b1;
    end else begin
      pin_q <= out_ctl_pin_n;
      if (!mode_taken) begin
        analog_mode <= !out_ctl_pin_n;
        mode_taken  <= 1'b1;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      filt_coef  <= FILT_COEF_RST;
      press_set  <= PRESS_DFLT;
      purge_ival <= IVAL_RST;
      comp_en    <= 1'b0;
      purge_wet  <= 1'b0;
      cmd_req    <= 1'b0;
    end else begin
      cmd_req <= wr_ctrl && !analog_mode && reg_wdata[CTL_PURGE_NOW];
      if (wr_coef) filt_coef <= reg_wdata;
      if (wr_press) press_set <= reg_wdata;
      if (wr_ival && ival_ok) purge_ival <= reg_wdata;
      if (wr_ctrl) begin
        comp_en   <= reg_wdata[CTL_COMP_EN];
        purge_wet <= reg_wdata[CTL_PURGE_WET];
      end
    end
  end

  // Read mux; unmapped offsets read zero.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_FILT_COEF:  reg_rdata <= filt_coef;
        REG_PRESS_SET:  reg_rdata <= press_set;
        REG_PURGE_CTRL: reg_rdata <= {30'h0, purge_wet, comp_en};
        REG_PURGE_IVAL: reg_rdata <= purge_ival;
        REG_STATUS:     reg_rdata <= {29'h0, defer_wait, analog_mode, purge_active};
        default:        reg_rdata <= '0;
      endcase
    end
  end

  // Compensation pressure follows the setpoint only when enabled.
  assign comp_pressure = comp_en ? press_set : PRESS_DFLT;

  // Peroxide is the plain sensor minus the water-only sensor.
  assign perox_raw = plain_rdg - catal_rdg;

  psf_filter #(.W(W)) u_perox (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .smp_valid (smp_valid && state == PSF_IDLE),
    .smp       (perox_raw),
    .coef      (filt_coef),
    .filt      (perox_f)
  );

  psf_filter #(.W(W)) u_water (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .smp_valid (smp_valid && state == PSF_IDLE),
    .smp       (catal_rdg),
    .coef      (filt_coef),
    .filt      (water_f)
  );

  // Outputs are masked during purge; the error code stands in for data.
  assign purge_active = (state == PSF_PURGE);
  assign meas_valid   = !purge_active && mode_taken;
  assign peroxide_out = purge_active ? W'(ERR_CODE) : perox_f;
  assign water_out    = purge_active ? W'(ERR_CODE) : water_f;
  assign analog_err   = analog_mode && purge_active;

  // Checks.
  a_purge_len: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(purge_active) |-> purge_active [*8])
    else $error("purge shorter than expected");
  a_mask_out: assert property (@(posedge core_clk) disable iff (!rst_b)
    purge_active |-> !meas_valid && peroxide_out == W'(ERR_CODE))
    else $error("measurement visible during purge");
  a_boot_purge: assert property (@(posedge core_clk)
    $rose(rst_b) |=> ##1 purge_active)
    else $error("no start-up purge");
  a_req_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
    purge_active && tmr != 0 |=> tmr == $past(tmr) + 1 || !purge_active)
    else $error("purge restarted by request");
  a_press_dflt: assert property (@(posedge core_clk) disable iff (!rst_b)
    !comp_en |-> comp_pressure == PRESS_DFLT)
    else $error("default pressure not used");
  a_err_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    analog_err |-> analog_mode && purge_active && !meas_valid)
    else $error("error level outside analog purge");
  a_defer_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !purge_active && per_due && blocked && !any_req |=> !purge_active)
    else $error("periodic purge not deferred");
  a_ival_range: assert property (@(posedge core_clk) disable iff (!rst_b)
    purge_ival >= PERIOD_MIN_H && purge_ival <= PERIOD_MAX_H)
    else $error("interval out of range");
  c_cmd_purge:  cover property (@(posedge core_clk) cmd_req ##1 purge_active);
  c_defer:      cover property (@(posedge core_clk) $rose(defer_wait));
  c_pin_purge:  cover property (@(posedge core_clk) pin_req ##1 analog_err);
endmodule // psf_top

// >>> src/psf_pkg.sv
// Package for the purge scheduler and output filter.
// Holds register offsets, reset values, field positions and timing constants.
package psf_pkg;
  // Clock rate in MHz.
  localparam int unsigned CLK_MHZ          = 200;
  // Times in their own units.
  localparam int unsigned PURGE_MIN        = 4;
  localparam int unsigned DEFER_MIN        = 30;
  localparam int unsigned PERIOD_DFLT_H    = 24;
  localparam int unsigned PERIOD_MIN_H     = 1;
  localparam int unsigned PERIOD_MAX_H     = 168;
  // Cycle counts derived from the rate.
  localparam longint unsigned CYC_PER_MIN  = 64'd60 * 64'd1000000 * CLK_MHZ;
  localparam longint unsigned PURGE_CYC    = PURGE_MIN * CYC_PER_MIN;
  localparam longint unsigned DEFER_CYC    = DEFER_MIN * CYC_PER_MIN;
  localparam longint unsigned HOUR_CYC     = 64'd60 * CYC_PER_MIN;
  // Register offsets.
  localparam logic [15:0] REG_FILT_COEF    = 16'h0308;
  localparam logic [15:0] REG_PRESS_SET    = 16'h0310;
  localparam logic [15:0] REG_PURGE_CTRL   = 16'h0314;
  localparam logic [15:0] REG_PURGE_IVAL   = 16'h0318;
  localparam logic [15:0] REG_STATUS       = 16'h031C;
  // Control register fields.
  localparam int unsigned CTL_COMP_EN      = 0;
  localparam int unsigned CTL_PURGE_WET    = 1;
  localparam int unsigned CTL_PURGE_NOW    = 2;
  // Reset values; coefficient is Q16.16 fixed point, pressure in 0.01 hPa.
  localparam logic [31:0] FILT_COEF_RST    = 32'h0001_0000;
  localparam logic [31:0] PRESS_DFLT       = 32'h0001_8BCD;
  localparam logic [31:0] IVAL_RST         = 32'h0000_0018;
  localparam logic [31:0] ERR_CODE         = 32'hFFFF_FFFF;
  // Scheduler states.
  typedef enum logic [1:0] {
    PSF_IDLE  = 2'b00,
    PSF_PURGE = 2'b01
  } psf_state_t;
endpackage

// >>> src/psf_filter.sv
// First-order output filter for one measurement channel.
// Assumes a Q16.16 coefficient in 0..1 and a registered sample strobe.
`timescale 1ns/1ps
module psf_filter
  import psf_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // Sample in
  input  wire logic          smp_valid,
  input  wire logic [W-1:0]  smp,
  input  wire logic [31:0]   coef,
  // Filtered out
  output logic      [W-1:0]  filt
);
  logic [16:0]       c;
  logic [W+16:0]     mix;
  logic              first;

  // Coefficient is clipped to one so the blend never overshoots.
  assign c   = (coef > FILT_COEF_RST) ? 17'h10000 : coef[16:0];
  assign mix = (W+17)'(c * smp) + (W+17)'((17'h10000 - c) * filt);

  // New output mixes latest sample with previous output.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      filt  <= '0;
      first <= 1'b1;
    end else if (smp_valid) begin
      filt  <= first ? smp : mix[W+15:16];
      first <= 1'b0;
    end
  end

  a_unity_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
    smp_valid && coef == FILT_COEF_RST |=> filt == $past(smp))
    else $error("unity coefficient did not pass sample");
endmodule // psf_filter

// >>> dv/psf_host_model.sv
// Host model: register master and output-control pin driver.
// Assumes the probe takes strobes on rising edges of core_clk.
`timescale 1ns/1ps
module psf_host_model (
  // Clock
  input  wire logic        core_clk,
  // Register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  // Output-control pin, high when left floating
  output logic             out_ctl_pin_n
);
  // Start idle with the pin floating, which selects the bus mode.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'hFFFF;
    reg_wdata = 32'hFFFF_FFFF;
    out_ctl_pin_n = 1'b1;
  end
  // One-cycle write; released lines go inverted so stale data never looks valid.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read strobe, then data is taken once the registered answer has settled.
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  // Ground or float the pin; a falling edge requests a purge in analog mode.
  task automatic pin(input logic v);
    @(posedge core_clk);
    out_ctl_pin_n <= v;
  endtask
endmodule // psf_host_model

// >>> dv/psf_top_bench.sv
// Self-checking bench for the purge scheduler and output filter.
// Assumes shortened purge, defer and hour counts given below.
`timescale 1ns/1ps
module psf_top_bench;
  import psf_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rh_adjust_done;
  logic        peroxide_present;
  logic        humidity_unsteady;
  logic        smp_valid;
  logic [31:0] plain_rdg;
  logic [31:0] catal_rdg;
  logic        reg_wr, reg_rd, out_ctl_pin_n, analog_mode, purge_active;
  logic        meas_valid, analog_err;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, peroxide_out, water_out, comp_pressure, d;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n, s;
  // Clock at 200 MHz.
  always #2.5 core_clk = ~core_clk;
  psf_host_model host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .out_ctl_pin_n);
  psf_top #(.PURGE_CYCLES(20), .DEFER_CYCLES(10), .HOUR_CYCLES(50)) DUT (
    .core_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .out_ctl_pin_n, .rh_adjust_done, .peroxide_present, .humidity_unsteady,
    .smp_valid, .plain_rdg, .catal_rdg, .analog_mode, .purge_active,
    .meas_valid, .peroxide_out, .water_out, .analog_err, .comp_pressure);
  // Cycle count; the ceiling sits far past the expected run length.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask
  // Wait up to lim cycles for a purge and note the cycle it was seen.
  task automatic till(input int lim);
    #1;
    n = 0;
    while (purge_active !== 1'b1 && n < lim) begin
      step();
      n++;
    end
    s = cyc;
  endtask
  // Wait out a purge and check that it lasted exactly the set count.
  task automatic plen;
    while (purge_active === 1'b1 && cyc - s < 200)
      step();
    chk(cyc - s, 20);
  endtask
  task automatic sample(input logic [31:0] p, input logic [31:0] c);
    @(posedge core_clk);
    smp_valid <= 1'b1;
    plain_rdg <= p;
    catal_rdg <= c;
    @(posedge core_clk);
    smp_valid <= 1'b0;
    repeat (3) step();
  endtask
  task automatic t_start;
    till(5);
    chk(n, 1);
    chk(meas_valid, 1'b0);
    chk(peroxide_out, ERR_CODE);
    chk(water_out, ERR_CODE);
    plen();
    chk(comp_pressure, PRESS_DFLT);
    host.rd(REG_FILT_COEF, d);
    chk(d, FILT_COEF_RST);
  endtask
  task automatic t_filt;
    sample(32'h500, 32'h200);
    chk(meas_valid, 1'b1);
    chk(peroxide_out, 32'h300);
    chk(water_out, 32'h200);
    host.wr(REG_FILT_COEF, 32'h8000);
    host.rd(REG_FILT_COEF, d);
    chk(d, 32'h8000);
    sample(32'h500, 32'h400);
    chk(peroxide_out, 32'h200);
    chk(water_out, 32'h300);
  endtask
  // A second command mid-purge must not stretch the running purge.
  task automatic t_cmd;
    host.wr(REG_PURGE_CTRL, 32'h4);
    till(3);
    chk(purge_active, 1'b1);
    host.rd(REG_STATUS, d);
    chk(d, 32'h1);
    repeat (5) step();
    host.wr(REG_PURGE_CTRL, 32'h4);
    plen();
    host.wr(REG_PRESS_SET, 32'h0001_8000);
    step();
    chk(comp_pressure, PRESS_DFLT);
    host.wr(REG_PURGE_CTRL, 32'h1);
    step();
    chk(comp_pressure, 32'h0001_8000);
    @(posedge core_clk);
    rh_adjust_done <= 1'b1;
    @(posedge core_clk);
    rh_adjust_done <= 1'b0;
    till(4);
    chk(purge_active, 1'b1);
    plen();
  endtask
  // Out-of-range intervals are refused; the timer restarts after a purge.
  task automatic t_period;
    host.wr(REG_PURGE_IVAL, 32'h1);
    host.wr(REG_PURGE_IVAL, 32'h0);
    host.wr(REG_PURGE_IVAL, 32'hA9);
    host.rd(REG_PURGE_IVAL, d);
    chk(d, 32'h1);
    host.wr(REG_PURGE_CTRL, 32'h5);
    till(3);
    plen();
    till(60);
    chk(n >= 48 && n <= 52, 1'b1);
    plen();
    @(posedge core_clk);
    humidity_unsteady <= 1'b1;
    peroxide_present <= 1'b1;
    till(70);
    chk(purge_active, 1'b0);
    @(posedge core_clk);
    humidity_unsteady <= 1'b0;
    host.wr(REG_PURGE_CTRL, 32'h3);
    till(25);
    chk(purge_active, 1'b1);
    plen();
    @(posedge core_clk);
    peroxide_present <= 1'b0;
  endtask
  // Second reset with the pin grounded selects analog mode.
  task automatic t_analog;
    host.pin(1'b0);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    till(5);
    chk(analog_mode, 1'b1);
    chk(analog_err, 1'b1);
    host.rd(REG_STATUS, d);
    chk(d, 32'h3);
    plen();
    chk(analog_err, 1'b0);
    host.pin(1'b1);
    repeat (3) step();
    host.pin(1'b0);
    till(5);
    chk(analog_err, 1'b1);
    plen();
    // The bus purge bit has no effect once the strap chose analog mode.
    host.wr(REG_PURGE_CTRL, 32'h4);
    repeat (3) step();
    chk(purge_active, 1'b0);
  endtask
  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after four cycles of reset.
  initial begin
    rh_adjust_done <= 1'b0;
    peroxide_present <= 1'b0;
    humidity_unsteady <= 1'b0;
    smp_valid <= 1'b0;
    plain_rdg <= 32'h0;
    catal_rdg <= 32'h0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    t_start();
    t_filt();
    t_cmd();
    t_period();
    t_analog();
    complete_run();
  end
endmodule // psf_top_bench
